// >>> hw/cpr_top.sv
`timescale 1ns/1ps
`include "cpr_cfg.svh"

module cpr_top #(
  parameter int unsigned WAKE_PULSE_CYCLES = `CPR_WAKE_PULSE_MS * (`CPR_CLK_HZ / 1000)
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // AXI4-Lite slave
  input  wire logic [`CPR_AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`CPR_AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Loader and neighbouring logic, same clock
  input  wire logic                    eeprom_load,
  input  wire logic [14:0]             eeprom_word,
  input  wire logic                    autoneg_done,
  input  wire logic                    autoneg_pause,
  input  wire logic                    wake_event,
  input  wire logic                    read_req_active,
  input  wire logic                    master_dw_strobe,
  input  wire logic                    cfg_pm_wr,
  input  wire logic [15:0]             cfg_pm_wdata,
  // Pins
  input  wire logic                    pci_rst_n,
  input  wire logic                    wake_pulse_i,
  output logic                         wake_pulse_o,
  output logic                         wake_pulse_oe,
  output logic                         pme_n_o,
  output logic                         pme_n_oe,
  // Configuration outputs
  output logic                         cold_state_support,
  output logic [2:0]                   aux_current_level,
  output logic                         led_count_select,
  output logic [1:0]                   rx_fifo_size,
  output logic                         clock_run_disable,
  output logic                         cap_ptr_zero,
  output logic                         pattern_wake_default,
  output logic                         pattern_pointer_reset,
  output logic                         pause_enable,
  output logic [1:0]                   rx_drain_threshold,
  output logic                         soft_interrupt,
  output logic                         underrun_auto_recovery,
  output logic [1:0]                   power_state_field,
  output logic                         wake_event_enable
);

  logic [31:0]                  cmd_r;
  logic [1:0]                   ps_r;
  logic [1:0]                   ps_prev_r;
  logic                         wake_status_r;
  logic                         wake_event_enable_r;
  logic                         wake_latch_r;
  logic                         pme_prev_r;
  logic [1:0]                   rst_sync_r;
  logic                         rst_prev_r;
  logic [1:0]                   pin_sync_r;
  logic                         aw_got_r;
  logic                         w_got_r;
  logic [`CPR_AXI_AW-1:0]       aw_addr_r;
  logic [31:0]                  w_data_r;
  logic [3:0]                   w_strb_r;
  logic                         bvalid_r;
  logic [1:0]                   bresp_r;
  logic [31:0]                  rdata_r;
  logic [1:0]                   rresp_r;
  cpr_pkg::cpr_rd_state_type    rd_state_r;

  logic                         do_write;
  logic [31:0]                  wr_mask;
  logic                         axi_pm_wr;
  logic                         st_clr;
  logic                         ps_wr;
  logic [1:0]                   ps_val;
  logic                         en_wr;
  logic                         en_val;
  logic [1:0]                   ps_nxt;
  logic                         back_to_d0;
  logic                         pci_rst_rise;
  logic                         pme_assert;
  logic                         pulse_busy;
  logic                         ar_hs;
  logic [31:0]                  rd_word;
  logic                         rd_ok;
  cpr_pkg::cpr_drain_type       drain_sel;

  cpr_cnt_if #(.W(16)) lat_if (.clk(ref_clk), .srst(srst));
  cpr_cnt_if #(.W(8))  dw_if  (.clk(ref_clk), .srst(srst));

  cpr_clr_counter #(.W(16)) u_lat_cnt (.bus(lat_if));
  cpr_clr_counter #(.W(8))  u_dw_cnt  (.bus(dw_if));

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Idle-high reset pin: no false rising edge after srst
      rst_sync_r <= 2'h3;
      pin_sync_r <= 2'h0;
      rst_prev_r <= 1'b1;
    end else begin
      rst_sync_r <= {rst_sync_r[0], pci_rst_n};
      pin_sync_r <= {pin_sync_r[0], wake_pulse_i};
      rst_prev_r <= rst_sync_r[1];
    end
  end

  assign pci_rst_rise = rst_sync_r[1] && !rst_prev_r;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign do_write      = aw_got_r && w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CPR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        case (aw_addr_r)
          `CPR_CMD_OFFSET, `CPR_PERF_OFFSET, `CPR_PM_OFFSET, `CPR_PIN_OFFSET: begin
            bresp_r <= `CPR_RESP_OKAY;
          end
          default: begin
            bresp_r <= `CPR_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Command register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_r <= `CPR_CMD_RESET;
    end else begin
      if (do_write && (aw_addr_r == `CPR_CMD_OFFSET)) begin
        cmd_r <= (cmd_r & ~(wr_mask & `CPR_CMD_WMASK))
               | (w_data_r & wr_mask & `CPR_CMD_WMASK);
      end
      if (autoneg_done) begin
        cmd_r[`CPR_PAUSE_BIT] <= autoneg_pause;
      end
      if (eeprom_load) begin
        cmd_r[31:`CPR_EE_LSB] <= eeprom_word;
      end
    end
  end

  // Power management register, shared by bus and configuration copies
  assign axi_pm_wr = do_write && (aw_addr_r == `CPR_PM_OFFSET);

  always_comb begin
    st_clr = (axi_pm_wr && w_strb_r[1] && w_data_r[`CPR_PM_STATUS_BIT])
          || (cfg_pm_wr && cfg_pm_wdata[`CPR_PM_STATUS_BIT]);
    ps_wr  = 1'b0;
    ps_val = ps_r;
    en_wr  = 1'b0;
    en_val = wake_event_enable_r;
    if (axi_pm_wr && w_strb_r[0]) begin
      ps_wr  = 1'b1;
      ps_val = w_data_r[1:0];
    end
    if (axi_pm_wr && w_strb_r[1]) begin
      en_wr  = 1'b1;
      en_val = w_data_r[`CPR_PM_EN_BIT];
    end
    if (cfg_pm_wr) begin
      ps_wr  = 1'b1;
      ps_val = cfg_pm_wdata[1:0];
      en_wr  = 1'b1;
      en_val = cfg_pm_wdata[`CPR_PM_EN_BIT];
    end
    ps_nxt = ps_r;
    if (ps_wr && ((ps_val == `CPR_PS_D0) || (ps_val == `CPR_PS_D3HOT))) begin
      ps_nxt = ps_val;
    end
    if (pci_rst_rise && cmd_r[`CPR_PS_CLR_BIT]) begin
      ps_nxt = `CPR_PS_D0;
    end
  end

  assign back_to_d0 = (ps_prev_r != `CPR_PS_D0) && (ps_r == `CPR_PS_D0);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ps_r                <= `CPR_PS_D0;
      ps_prev_r           <= `CPR_PS_D0;
      wake_event_enable_r <= 1'b0;
    end else begin
      ps_r      <= ps_nxt;
      ps_prev_r <= ps_r;
      if (en_wr) begin
        wake_event_enable_r <= en_val;
      end
    end
  end

  // Wake status: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_status_r <= 1'b0;
    end else begin
      wake_status_r <= wake_event || (wake_status_r && !st_clr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_latch_r <= 1'b0;
    end else if (wake_event) begin
      wake_latch_r <= 1'b1;
    end else if (st_clr) begin
      wake_latch_r <= 1'b0;
    end else if (back_to_d0 && !cmd_r[`CPR_STICKY_BIT]) begin
      wake_latch_r <= 1'b0;
    end
  end

  assign pme_assert = cmd_r[`CPR_FORCE_BIT] || (wake_latch_r && wake_event_enable_r);

  cpr_pulse_gen #(.CYCLES(WAKE_PULSE_CYCLES)) u_wake_pulse (
    .ref_clk (ref_clk),
    .srst    (srst),
    .trigger (pme_assert && !pme_prev_r),
    .busy    (pulse_busy)
  );

  // Wake pins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pme_prev_r    <= 1'b0;
      pme_n_o       <= 1'b0;
      pme_n_oe      <= 1'b0;
      wake_pulse_o  <= 1'b0;
      wake_pulse_oe <= 1'b0;
    end else begin
      pme_prev_r    <= pme_assert;
      pme_n_o       <= 1'b0;
      pme_n_oe      <= pme_assert;
      wake_pulse_o  <= pulse_busy ^ cmd_r[`CPR_PULSE_POL_BIT];
      wake_pulse_oe <= cmd_r[`CPR_PULSE_EN_BIT];
    end
  end

  // Configuration outputs
  assign drain_sel = cmd_r[`CPR_RTE_BIT] ? cpr_pkg::cpr_drain_type'(cmd_r[`CPR_DRT_HI:`CPR_DRT_LO])
                                          : cpr_pkg::CPR_DRAIN_64;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cold_state_support     <= 1'b0;
      aux_current_level      <= 3'h0;
      led_count_select       <= 1'b0;
      rx_fifo_size           <= cpr_pkg::CPR_FIFO_2K;
      clock_run_disable      <= 1'b0;
      cap_ptr_zero           <= 1'b0;
      pattern_wake_default   <= 1'b0;
      pattern_pointer_reset  <= 1'b0;
      pause_enable           <= 1'b0;
      rx_drain_threshold     <= cpr_pkg::CPR_DRAIN_64;
      soft_interrupt         <= 1'b0;
      underrun_auto_recovery <= 1'b0;
      power_state_field      <= `CPR_PS_D0;
      wake_event_enable      <= 1'b0;
    end else begin
      cold_state_support     <= cmd_r[`CPR_COLD_BIT];
      aux_current_level      <= cmd_r[`CPR_AUX_HI:`CPR_AUX_LO];
      led_count_select       <= cmd_r[`CPR_LED_BIT];
      rx_fifo_size           <= cmd_r[`CPR_RFS_HI:`CPR_RFS_LO];
      clock_run_disable      <= cmd_r[`CPR_CRD_BIT];
      cap_ptr_zero           <= !cmd_r[`CPR_PM_BIT];
      pattern_wake_default   <= cmd_r[`CPR_PM_BIT] && cmd_r[`CPR_APM_BIT];
      pattern_pointer_reset  <= cmd_r[`CPR_PTR_RST_BIT];
      pause_enable           <= cmd_r[`CPR_PAUSE_BIT];
      rx_drain_threshold     <= drain_sel;
      soft_interrupt         <= cmd_r[`CPR_SOFT_INTERRUPT_BIT];
      underrun_auto_recovery <= cmd_r[`CPR_UNDERRUN_AUTO_RECOVERY_BIT];
      power_state_field      <= ps_r;
      wake_event_enable      <= wake_event_enable_r;
    end
  end

  // Performance counters
  assign lat_if.inc = read_req_active;
  assign dw_if.inc  = master_dw_strobe;
  assign lat_if.clr = ar_hs && (s_axi_araddr == `CPR_PERF_OFFSET);
  assign dw_if.clr  = lat_if.clr;

  // Read channel
  assign s_axi_arready = (rd_state_r == cpr_pkg::CPR_RD_IDLE);
  assign s_axi_rvalid  = (rd_state_r == cpr_pkg::CPR_RD_DATA);
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `CPR_CMD_OFFSET: begin
        rd_word = cmd_r;
      end
      `CPR_PERF_OFFSET: begin
        rd_word = {lat_if.value, 8'h00, dw_if.value};
      end
      `CPR_PM_OFFSET: begin
        rd_word[`CPR_PM_STATUS_BIT] = wake_status_r;
        rd_word[`CPR_PM_EN_BIT]     = wake_event_enable_r;
        rd_word[1:0]                = ps_r;
      end
      `CPR_PIN_OFFSET: begin
        rd_word[1] = pulse_busy;
        rd_word[0] = pin_sync_r[1];
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_state_r <= cpr_pkg::CPR_RD_IDLE;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= `CPR_RESP_OKAY;
    end else begin
      case (rd_state_r)
        cpr_pkg::CPR_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_r <= cpr_pkg::CPR_RD_DATA;
            rdata_r    <= rd_word;
            rresp_r    <= rd_ok ? `CPR_RESP_OKAY : `CPR_RESP_SLVERR;
          end
        end
        cpr_pkg::CPR_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_r <= cpr_pkg::CPR_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= cpr_pkg::CPR_RD_IDLE;
        end
      endcase
    end
  end

endmodule : cpr_top

// >>> include/cpr_cfg.svh
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH

// Bus address width and register byte offsets
`define CPR_AXI_AW         8
`define CPR_CMD_OFFSET     8'h88
`define CPR_PERF_OFFSET    8'h8C
`define CPR_PM_OFFSET      8'h90
`define CPR_PIN_OFFSET     8'hC0

// Command register
`define CPR_CMD_RESET      32'hA04C0004
`define CPR_CMD_WMASK      32'h8FF600FF
`define CPR_EE_LSB         17
`define CPR_COLD_BIT       31
`define CPR_AUX_HI         30
`define CPR_AUX_LO         28
`define CPR_PULSE_POL_BIT  27
`define CPR_PULSE_EN_BIT   26
`define CPR_PS_CLR_BIT     25
`define CPR_STICKY_BIT     24
`define CPR_LED_BIT        23
`define CPR_RFS_HI         22
`define CPR_RFS_LO         21
`define CPR_CRD_BIT        20
`define CPR_PM_BIT         19
`define CPR_APM_BIT        18
`define CPR_FORCE_BIT      7
`define CPR_PTR_RST_BIT    6
`define CPR_PAUSE_BIT      5
`define CPR_RTE_BIT        4
`define CPR_DRT_HI         3
`define CPR_DRT_LO         2
`define CPR_SOFT_INTERRUPT_BIT       1
`define CPR_UNDERRUN_AUTO_RECOVERY_BIT       0

// Power management register
`define CPR_PM_STATUS_BIT  15
`define CPR_PM_EN_BIT      8
`define CPR_PS_D0          2'h0
`define CPR_PS_D3HOT       2'h3

// Bus answers
`define CPR_RESP_OKAY      2'h0
`define CPR_RESP_SLVERR    2'h2

// Timing
`define CPR_WAKE_PULSE_MS  50
`define CPR_CLK_HZ         25000000

`endif

// >>> include/cpr_pkg.sv
package cpr_pkg;

  typedef enum logic [1:0] {
    CPR_RD_IDLE = 2'b01,
    CPR_RD_DATA = 2'b10
  } cpr_rd_state_type;

  typedef enum logic [1:0] {
    CPR_FIFO_RSV0 = 2'h0,
    CPR_FIFO_RSV1 = 2'h1,
    CPR_FIFO_2K   = 2'h2,
    CPR_FIFO_1K   = 2'h3
  } cpr_fifo_size_type;

  typedef enum logic [1:0] {
    CPR_DRAIN_32  = 2'h0,
    CPR_DRAIN_64  = 2'h1,
    CPR_DRAIN_SAF = 2'h2,
    CPR_DRAIN_RSV = 2'h3
  } cpr_drain_type;

endpackage : cpr_pkg

// >>> include/cpr_cnt_if.sv
`timescale 1ns/1ps
interface cpr_cnt_if #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst
);
  logic         inc;
  logic         clr;
  logic [W-1:0] value;

  modport ctr (input clk, input srst, input inc, input clr, output value);
  modport usr (output inc, output clr, input value);
endinterface : cpr_cnt_if

// >>> hw/cpr_clr_counter.sv
`timescale 1ns/1ps
module cpr_clr_counter #(
  parameter int W = 8
) (
  cpr_cnt_if.ctr bus
);
  logic [W-1:0] value_r;

  // Clear-on-read; an increment in the clearing cycle is kept
  always_ff @(posedge bus.clk) begin
    if (bus.srst) begin
      value_r <= '0;
    end else if (bus.clr) begin
      value_r <= bus.inc ? W'(1) : '0;
    end else if (bus.inc && (value_r != '1)) begin
      value_r <= value_r + W'(1);
    end
  end

  assign bus.value = value_r;
endmodule : cpr_clr_counter

// >>> hw/cpr_pulse_gen.sv
`timescale 1ns/1ps
module cpr_pulse_gen #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic trigger,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_r;

  // Fixed-length pulse; triggers during a pulse are ignored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (count_r != '0) begin
      count_r <= count_r - CW'(1);
    end else if (trigger) begin
      count_r <= CW'(CYCLES);
    end
  end

  assign busy = (count_r != '0);
endmodule : cpr_pulse_gen

// >>> tb/cpr_sva.sv
`timescale 1ns/1ps
module cpr_sva_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        read_req_active,
  input wire logic        master_dw_strobe,
  input wire logic        wake_event,
  input wire logic        pme_n_oe,
  input wire logic        cap_ptr_zero,
  input wire logic        pattern_wake_default
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [7:0]  wa_r;
  logic [31:0] wd_r;
  logic [7:0]  ra_r;
  logic        rq_r;
  logic [15:0] lat_r;
  logic [7:0]  dw_r;
  logic        perf_rd;
  assign perf_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h8C;
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
    rq_r <= s_axi_arvalid && s_axi_arready && !srst;
    ra_r <= s_axi_araddr;
  end
  // Reference counters, restarted by a read of the counter register
  always_ff @(posedge ref_clk) begin
    if (srst || perf_rd) begin
      lat_r <= {15'h0, read_req_active && !srst};
      dw_r  <= {7'h0, master_dw_strobe && !srst};
    end else begin
      if (read_req_active && lat_r != 16'hFFFF) lat_r <= lat_r + 16'h1;
      if (master_dw_strobe && dw_r != 8'hFF) dw_r <= dw_r + 8'h1;
    end
  end
  a_lat_count: assert property (
    $past(perf_rd) |-> s_axi_rdata[31:16] == $past(lat_r)) else $error("latency count wrong");
  a_dw_count: assert property (
    $past(perf_rd) |-> s_axi_rdata[7:0] == $past(dw_r)) else $error("doubleword count wrong");
  a_cmd_resv: assert property (
    rq_r && ra_r == 8'h88 |-> s_axi_rdata[16:8] == 9'h000) else $error("command reserved bits set");
  a_pm_resv: assert property (
    rq_r && ra_r == 8'h90 |-> (s_axi_rdata & 32'hFFFF7EFC) == 32'h0) else $error("power reserved bits set");
  a_unmap_err: assert property (
    rq_r && !(ra_r inside {8'h88, 8'h8C, 8'h90, 8'hC0}) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_pm_gate: assert property (
    pattern_wake_default |-> !cap_ptr_zero) else $error("pattern default without power management");
  a_force_on: assert property (
    $rose(s_axi_bvalid) && wa_r == 8'h88 && wd_r[7] |-> ##[1:2] pme_n_oe) else $error("forced wake missing");
  a_status_clr: assert property (
    $rose(s_axi_bvalid) && wa_r == 8'h90 && wd_r[15] && !wake_event |-> ##[1:2] !pme_n_oe)
    else $error("wake event not released");
endmodule : cpr_sva_chk

bind cpr_top cpr_sva_chk u_sva (
  .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .read_req_active(read_req_active), .master_dw_strobe(master_dw_strobe),
  .wake_event(wake_event), .pme_n_oe(pme_n_oe), .cap_ptr_zero(cap_ptr_zero),
  .pattern_wake_default(pattern_wake_default)
);

// >>> tb/cpr_host_model.sv
`timescale 1ns/1ps
module cpr_host_model (
  input wire logic        ref_clk,
  output logic [7:0]      awaddr,
  output logic            awvalid,
  input wire logic        awready,
  output logic [31:0]     wdata,
  output logic [3:0]      wstrb,
  output logic            wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  output logic            bready,
  output logic [7:0]      araddr,
  output logic            arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  output logic            rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} <= '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= (a == 8'h88) ? (d & ~32'h00020000) : d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Released payload is inverted so a stale value is never mistaken for a live one
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
      if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge ref_clk); while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    {arvalid, araddr} <= {1'b0, ~a};
    do @(posedge ref_clk); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : cpr_host_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int PULSE = 20;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rx_fifo_size, rx_drain_threshold, power_state_field;
  logic [2:0]  aux_current_level;
  logic        pme_n_o, cold_state_support, wake_event_enable, cfg_pm_wr = 1'b0;
  logic [15:0] cfg_pm_wdata = 16'h0000;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        wake_pulse_o, wake_pulse_oe, pme_n_oe, led_count_select, clock_run_disable, cap_ptr_zero;
  logic        pattern_wake_default, pattern_pointer_reset, pause_enable, soft_interrupt, underrun_auto_recovery;
  logic        eeprom_load = 1'b0, autoneg_done = 1'b0, wake_event = 1'b0, read_req_active = 1'b0;
  logic        master_dw_strobe = 1'b0, pci_rst_n = 1'b1;
  logic [14:0] eeprom_word = 15'h0000;
  int          lo_cnt = 0, miscompares = 0, check_count = 0;

  cpr_top #(.WAKE_PULSE_CYCLES(PULSE)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eeprom_load(eeprom_load), .eeprom_word(eeprom_word),
    .autoneg_done(autoneg_done), .autoneg_pause(1'b0), .wake_event(wake_event),
    .read_req_active(read_req_active), .master_dw_strobe(master_dw_strobe), .cfg_pm_wr(cfg_pm_wr),
    .cfg_pm_wdata(cfg_pm_wdata), .pci_rst_n(pci_rst_n), .wake_pulse_i(1'b0), .wake_pulse_o(wake_pulse_o),
    .wake_pulse_oe(wake_pulse_oe), .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .cold_state_support(cold_state_support),
    .aux_current_level(aux_current_level), .led_count_select(led_count_select), .rx_fifo_size(rx_fifo_size),
    .clock_run_disable(clock_run_disable), .cap_ptr_zero(cap_ptr_zero), .pattern_wake_default(pattern_wake_default),
    .pattern_pointer_reset(pattern_pointer_reset), .pause_enable(pause_enable),
    .rx_drain_threshold(rx_drain_threshold), .soft_interrupt(soft_interrupt),
    .underrun_auto_recovery(underrun_auto_recovery), .power_state_field(power_state_field),
    .wake_event_enable(wake_event_enable)
  );
  cpr_host_model u_host (
    .ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  always #20 ref_clk = ~ref_clk;
  // Low cycles of the driven wake pulse pin
  always @(posedge ref_clk) if (wake_pulse_oe === 1'b1 && wake_pulse_o === 1'b0) lo_cnt <= lo_cnt + 1;

  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    u_host.rd(a, d, r);
    chk($sformatf("read %h", a), e, d);
    chk($sformatf("read response %h", a), (a == 8'h94) ? 32'h2 : 32'h0, {30'h0, r});
  endtask : rc
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    u_host.wr(a, d, s, r);
    chk("write response", 32'h0, {30'h0, r});
  endtask : wc
  task automatic wake();
    wake_event <= 1'b1;
    cyc(1);
    wake_event <= 1'b0;
    cyc(3);
  endtask : wake

  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    results();
  end
  initial begin
    wait (!srst);
    rc(8'h88, 32'hA04C0004);
    rc(8'h8C, 32'h0);
    rc(8'h90, 32'h0);
    rc(8'h94, 32'h0);
    rc(8'hC0, 32'h0);
    wc(8'h88, 32'hFFFFFFFF, 4'hF);
    cyc(3);
    chk("forced wake", 32'h2A, {26'h0, cold_state_support, aux_current_level, pme_n_oe, pme_n_o});
    cyc(30);
    chk("pulse length", PULSE, lo_cnt);
    rc(8'h88, 32'hAFFC00FF);
    chk("config outputs", 32'h1FFD, {led_count_select, rx_fifo_size, clock_run_disable, rx_drain_threshold,
      soft_interrupt, underrun_auto_recovery, pattern_pointer_reset, pause_enable, wake_pulse_oe,
      cap_ptr_zero, pattern_wake_default});
    autoneg_done <= 1'b1;
    cyc(1);
    autoneg_done <= 1'b0;
    cyc(2);
    chk("pause", 32'h0, {31'h0, pause_enable});
    wc(8'h88, 32'h00000008, 4'h1);
    cyc(3);
    chk("drain and wake", 32'h1, {29'h0, pme_n_oe, rx_drain_threshold});
    rc(8'h88, 32'hAFFC0008);
    read_req_active <= 1'b1;
    cyc(5);
    read_req_active <= 1'b0;
    master_dw_strobe <= 1'b1;
    cyc(300);
    master_dw_strobe <= 1'b0;
    rc(8'h8C, 32'h000500FF);
    rc(8'h8C, 32'h0);
    wake();
    rc(8'h90, 32'h00008000);
    chk("wake disabled", 32'h0, {31'h0, pme_n_oe});
    wc(8'h90, 32'h00008000, 4'hF);
    rc(8'h90, 32'h0);
    cfg_pm_wdata <= 16'h0103;
    cfg_pm_wr <= 1'b1;
    cyc(1);
    cfg_pm_wr <= 1'b0;
    rc(8'h90, 32'h00000103);
    wc(8'h90, 32'h00000103, 4'hF);
    wake();
    rc(8'h90, 32'h00008103);
    pci_rst_n <= 1'b0;
    cyc(3);
    pci_rst_n <= 1'b1;
    cyc(6);
    rc(8'h90, 32'h00008100);
    chk("sticky wake", 32'hC, {28'h0, pme_n_oe, wake_event_enable, power_state_field});
    wc(8'h90, 32'h00008100, 4'hF);
    cyc(2);
    chk("cleared wake", 32'h0, {31'h0, pme_n_oe});
    wc(8'h88, 32'h86000000, 4'h8);
    wc(8'h90, 32'h00000103, 4'hF);
    wake();
    chk("wake asserted", 32'h3, {30'h0, pme_n_oe, wake_pulse_o});
    wc(8'h90, 32'h00000100, 4'hF);
    cyc(3);
    chk("auto release", 32'h0, {31'h0, pme_n_oe});
    eeprom_word <= 15'h0002;
    eeprom_load <= 1'b1;
    cyc(1);
    eeprom_load <= 1'b0;
    cyc(2);
    rc(8'h88, 32'h00040008);
    chk("power mgmt off", 32'h2, {29'h0, wake_pulse_oe, cap_ptr_zero, pattern_wake_default});
    results();
  end
endmodule : tb_top
